// ---- dfa_consts.svh ----
// Constants for the data flash access control block
// Operation
// - Erase works only on whole 1 KB blocks, never smaller.
// - Every array access is one byte; word accesses are refused.
// - Plain CPU loads read the array directly while access is enabled.
// - Code flash fetches keep being served during data flash rewrite.
// - Instruction fetches from the data flash array are refused.
// - All array access is refused while code flash self-programs.
// - Control register writes are ignored while data flash rewrites.
// - STOP mode entry is blocked while data flash rewrites.
// - Array is stopped after reset until software sets the enable.
// - Control bit 0 enables (1) or disables (0) all array access outside serial programming mode.
// - Reset clears the control register to zero.
// - Control register takes single-bit and full-byte writes.
// - Small variant needs interrupts masked during rewrite.
// - Serial programming interface may also rewrite the array.
`ifndef DFA_CONSTS_SVH
`define DFA_CONSTS_SVH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define DFA_CTRL_ADDR 20'hF0090
`define DFA_CTRL_RESET 8'h00
`define DFA_CTRL_EN_BIT 0
`define DFA_CTRL_MASK 8'h01
// ------------------------------------------------------------
// Array geometry
// ------------------------------------------------------------
`define DFA_BASE_ADDR 20'hF1000
`define DFA_BLOCK_BITS 10
`define DFA_SIZE_BITS 11
`endif

// ---- dfa_pkg.sv ----
// Types shared by the data flash access control block
`default_nettype none
package dfa_pkg;
    // CPU memory request, same clock as the block
    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic word;
        logic bit_op;
        logic [2:0] bit_sel;
        logic [19:0] addr;
        logic [7:0] wdata;
    } dfa_req_t;
    // Rewrite command from the library or the serial programmer
    typedef enum logic [1:0] {
        DFA_OP_NONE = 2'b00,
        DFA_OP_ERASE = 2'b01,
        DFA_OP_PROG = 2'b10
    } dfa_op_t;
    typedef struct packed {
        dfa_op_t op;
        logic [19:0] addr;
        logic [7:0] data;
    } dfa_cmd_t;
    // Rewrite sequencer states
    typedef enum logic [1:0] {
        DFA_ST_IDLE = 2'b00,
        DFA_ST_ERASE = 2'b01,
        DFA_ST_PROG = 2'b10
    } dfa_state_t;
endpackage : dfa_pkg
`default_nettype wire

// ---- dfa_sync.sv ----
// Two-stage synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module dfa_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Asynchronous level in, synchronised level out
    input wire logic i_async,
    output logic o_sync
);
    logic stage1;
    // First stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule : dfa_sync
`default_nettype wire

// ---- dfa_top.sv ----
// Data flash access control: register, read gating and rewrite control
`timescale 1ns/1ps
`default_nettype none
`include "dfa_consts.svh"
module dfa_top
    import dfa_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // CPU memory port
    input wire dfa_req_t i_req,
    output logic o_ack,
    output logic o_err,
    output logic [7:0] o_rdata,
    // Code flash fetch forwarding
    output logic o_cf_fetch,
    // Data flash array macro
    output logic [`DFA_SIZE_BITS-1:0] o_arr_raddr,
    input wire logic [7:0] i_arr_rdata,
    output logic o_arr_erase,
    output logic o_arr_prog,
    output logic [`DFA_SIZE_BITS-1:0] o_arr_waddr,
    output logic [7:0] o_arr_wdata,
    input wire logic i_arr_done,
    // Rewrite command from library or serial programmer
    input wire dfa_cmd_t i_cmd,
    output logic o_cmd_ack,
    output logic o_cmd_err,
    // Chip status
    input wire logic i_cf_selfprog,
    input wire logic i_global_irq_enable,
    input wire logic i_serial_prog_pin,
    // Low power
    input wire logic i_stop_req,
    output logic o_stop_grant,
    output logic o_background_rewrite
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] data_flash_control_reg;
    logic data_flash_access_enable;
    logic serial_mode;
    dfa_state_t state;
    dfa_state_t next_state;
    logic in_array;
    logic hit_ctrl;
    logic rewriting;
    logic cmd_ok;
    logic [7:0] next_ctrl;
    logic [`DFA_SIZE_BITS-1:0] arr_off;

    // Serial programming pin into clock domain
    dfa_sync u_serial_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(i_serial_prog_pin),
        .o_sync(serial_mode)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign in_array = (i_req.addr >= `DFA_BASE_ADDR) &&
        (i_req.addr < (`DFA_BASE_ADDR + 20'h00800));
    assign hit_ctrl = (i_req.addr == `DFA_CTRL_ADDR);
    assign arr_off = i_req.addr[`DFA_SIZE_BITS-1:0];
    assign data_flash_access_enable =
        data_flash_control_reg[`DFA_CTRL_EN_BIT];
    assign rewriting = (state != DFA_ST_IDLE);
    assign o_background_rewrite = rewriting;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Byte write or single-bit set/clear; upper bits stay zero
    always_comb begin
        next_ctrl = data_flash_control_reg;
        if (i_req.bit_op) begin
            next_ctrl[i_req.bit_sel] = i_req.wdata[0];
        end else begin
            next_ctrl = i_req.wdata;
        end
        next_ctrl = next_ctrl & `DFA_CTRL_MASK;
    end

    // Writes ignored during a rewrite
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data_flash_control_reg <= `DFA_CTRL_RESET;
        end else if (i_req.valid && i_req.write && hit_ctrl &&
                     !rewriting) begin
            data_flash_control_reg <= next_ctrl;
        end
    end

    // ------------------------------------------------------------
    // CPU access path
    // ------------------------------------------------------------
    assign o_arr_raddr = arr_off;
    // Code flash fetches pass through regardless of rewrite state
    assign o_cf_fetch = i_req.valid && i_req.fetch && !in_array;

    // One-cycle answer: array byte, register, or refusal
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ack <= 1'b0;
            o_err <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            o_ack <= 1'b0;
            o_err <= 1'b0;
            if (i_req.valid && hit_ctrl && !i_req.fetch) begin
                o_ack <= 1'b1;
                o_err <= i_req.word;
                o_rdata <= data_flash_control_reg;
            end else if (i_req.valid && in_array) begin
                o_ack <= 1'b1;
                if (i_req.fetch || i_req.word || i_req.write ||
                    !data_flash_access_enable || i_cf_selfprog ||
                    rewriting) begin
                    o_err <= 1'b1;
                    o_rdata <= 8'h00;
                end else begin
                    o_rdata <= i_arr_rdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Rewrite sequencer
    // ------------------------------------------------------------
    // Commands need enable or serial mode, no code flash rewrite
    assign cmd_ok = (i_cmd.op != DFA_OP_NONE) && !rewriting &&
        (data_flash_access_enable || serial_mode) &&
        !i_cf_selfprog &&
        !(SMALL_VARIANT && i_global_irq_enable && !serial_mode) &&
        ((i_cmd.addr >= `DFA_BASE_ADDR) &&
         (i_cmd.addr < (`DFA_BASE_ADDR + 20'h00800)));

    always_comb begin
        next_state = state;
        case (state)
            DFA_ST_IDLE: begin
                if (cmd_ok && i_cmd.op == DFA_OP_ERASE) begin
                    next_state = DFA_ST_ERASE;
                end else if (cmd_ok && i_cmd.op == DFA_OP_PROG) begin
                    next_state = DFA_ST_PROG;
                end
            end
            DFA_ST_ERASE, DFA_ST_PROG: begin
                if (i_arr_done) begin
                    next_state = DFA_ST_IDLE;
                end
            end
            default: next_state = DFA_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= DFA_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Macro strobes and command answer
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arr_erase <= 1'b0;
            o_arr_prog <= 1'b0;
            o_arr_waddr <= '0;
            o_arr_wdata <= 8'h00;
            o_cmd_ack <= 1'b0;
            o_cmd_err <= 1'b0;
        end else begin
            o_arr_erase <= 1'b0;
            o_arr_prog <= 1'b0;
            o_cmd_ack <= 1'b0;
            o_cmd_err <= 1'b0;
            if (state == DFA_ST_IDLE && i_cmd.op != DFA_OP_NONE) begin
                o_cmd_ack <= cmd_ok;
                o_cmd_err <= !cmd_ok;
                if (cmd_ok && i_cmd.op == DFA_OP_ERASE) begin
                    o_arr_erase <= 1'b1;
                    o_arr_waddr <= {i_cmd.addr[`DFA_SIZE_BITS-1:
                        `DFA_BLOCK_BITS], {`DFA_BLOCK_BITS{1'b0}}};
                end else if (cmd_ok) begin
                    o_arr_prog <= 1'b1;
                    o_arr_waddr <= i_cmd.addr[`DFA_SIZE_BITS-1:0];
                    o_arr_wdata <= i_cmd.data;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // STOP mode interlock
    // ------------------------------------------------------------
    assign o_stop_grant = i_stop_req && !rewriting;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    stop_block_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        rewriting |-> !o_stop_grant)
        else $error("STOP granted during rewrite");
    ctrl_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        rewriting |=> $stable(data_flash_control_reg))
        else $error("Control changed during rewrite");
    ctrl_upper_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        data_flash_control_reg[7:1] == 7'h00)
        else $error("Reserved control bits set");
    fetch_refuse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.valid && i_req.fetch && in_array) |=> (o_ack && o_err))
        else $error("Fetch from data array not refused");
    self_prog_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.valid && in_array && i_cf_selfprog) |=> o_err)
        else $error("Access during code flash rewrite");
    read_ok_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.valid && in_array && !i_req.fetch && !i_req.word &&
         !i_req.write && data_flash_access_enable && !i_cf_selfprog &&
         !rewriting) |=> (o_ack && !o_err &&
         o_rdata == $past(i_arr_rdata)))
        else $error("Direct read not served");
    disabled_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.valid && in_array && !data_flash_access_enable)
        |=> o_err)
        else $error("Access while disabled");
    word_refuse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.valid && in_array && i_req.word) |=> o_err)
        else $error("Word access not refused");
    erase_align_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_arr_erase |-> (o_arr_waddr[`DFA_BLOCK_BITS-1:0] == '0))
        else $error("Erase not block aligned");
    fetch_pass_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.valid && i_req.fetch && !in_array) |-> o_cf_fetch)
        else $error("Code fetch dropped");
    byte_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_req.valid && i_req.write && hit_ctrl && !i_req.bit_op &&
         !rewriting) |=> data_flash_control_reg ==
         ($past(i_req.wdata) & 8'h01))
        else $error("Byte write not taken");
endmodule : dfa_top
`default_nettype wire

// ---- dfa_arr_model.sv ----
// Behavioural data flash array macro facing the access control block
`timescale 1ns/1ps
`default_nettype none
`include "dfa_consts.svh"
module dfa_arr_model #(
    parameter int BUSY_CYC = 6
) (
    // Clock
    input wire logic i_clk,
    // Read side
    input wire logic [`DFA_SIZE_BITS-1:0] i_raddr,
    output logic [7:0] o_rdata,
    // Rewrite side
    input wire logic i_erase,
    input wire logic i_prog,
    input wire logic [`DFA_SIZE_BITS-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    output logic o_done
);
    logic [7:0] mem [0:2047];
    int cnt = 0;
    // Known fill pattern so reads can be predicted
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
    end
    // Byte read straight from the cell array
    assign o_rdata = mem[i_raddr];
    // Rewrite takes a while, then a one-cycle done pulse
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        if (i_erase) begin
            for (int j = 0; j < 1024; j++) begin
                mem[{i_waddr[10], j[9:0]}] <= 8'hFF;
            end
            cnt <= BUSY_CYC;
        end else if (i_prog) begin
            mem[i_waddr] <= mem[i_waddr] & i_wdata;
            cnt <= BUSY_CYC;
        end else if (cnt == 1) begin
            o_done <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : dfa_arr_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the data flash access control block
`timescale 1ns/1ps
`default_nettype none
`include "dfa_consts.svh"
module testbench;
    import dfa_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    dfa_req_t req = '0;
    dfa_cmd_t cmd = '0;
    logic selfprog = 1'b0;
    logic irq_en = 1'b0;
    logic spin = 1'b0;
    logic stop_req = 1'b0;
    logic ack, err, cf_fetch, erase, prog, done, cack, cerr, grant, background_rewrite;
    logic [7:0] rdata, ardata, wdata;
    logic [10:0] raddr, waddr;
    int n_fail = 0;
    int tests_run = 0;
    // ----------------------------------------
    // Clock, design and array model
    // ----------------------------------------
    always #50 i_clk = ~i_clk;
    // Small variant so the interrupt interlock is exercised too
    dfa_top #(.SMALL_VARIANT(1'b1)) uut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_req(req), .o_ack(ack),
        .o_err(err), .o_rdata(rdata), .o_cf_fetch(cf_fetch),
        .o_arr_raddr(raddr), .i_arr_rdata(ardata), .o_arr_erase(erase),
        .o_arr_prog(prog), .o_arr_waddr(waddr), .o_arr_wdata(wdata),
        .i_arr_done(done), .i_cmd(cmd), .o_cmd_ack(cack), .o_cmd_err(cerr),
        .i_cf_selfprog(selfprog), .i_global_irq_enable(irq_en),
        .i_serial_prog_pin(spin), .i_stop_req(stop_req),
        .o_stop_grant(grant), .o_background_rewrite(background_rewrite));
    dfa_arr_model arr (.i_clk(i_clk), .i_raddr(raddr), .o_rdata(ardata),
        .i_erase(erase), .i_prog(prog), .i_waddr(waddr), .i_wdata(wdata),
        .o_done(done));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [19:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One CPU access, answer judged one cycle later
    task automatic cpu(input logic wr, fe, wd, bo, input logic [2:0] bs,
        input logic [19:0] a, input logic [7:0] d, input logic e_err,
        input logic [7:0] e_rd);
        @(negedge i_clk);
        req = '{valid:1'b1, write:wr, fetch:fe, word:wd, bit_op:bo,
            bit_sel:bs, addr:a, wdata:d};
        @(negedge i_clk);
        check("ack", ack, 1'b1);
        check("err", err, e_err);
        if (!wr) check("rdata", rdata, e_rd);
        req.valid = 1'b0;
    endtask : cpu
    task automatic rd(input logic [19:0] a, input logic e_err,
        input logic [7:0] e_rd);
        cpu(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, a, 8'h00, e_err, e_rd);
    endtask : rd
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        cpu(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, a, d, 1'b0, 8'h00);
    endtask : wr
    // One rewrite command; an accepted one is followed to its end
    task automatic cmd_go(input dfa_op_t op, input logic [19:0] a,
        input logic [7:0] d, input logic e_err);
        int k;
        @(negedge i_clk);
        cmd = '{op:op, addr:a, data:d};
        stop_req = 1'b1;
        @(negedge i_clk);
        cmd.op = DFA_OP_NONE;
        check("cmd_ack", cack, !e_err);
        check("cmd_err", cerr, e_err);
        if (!e_err) begin
            check("erase", erase, op == DFA_OP_ERASE);
            check("prog", prog, op == DFA_OP_PROG);
            check("waddr", waddr, op == DFA_OP_ERASE ?
                {a[10], 10'h000} : a[10:0]);
            check("bgo", background_rewrite, 1'b1);
            check("stop_grant", grant, 1'b0);
            k = 0;
            while (background_rewrite === 1'b1 && k < 40) begin
                @(negedge i_clk);
                k++;
            end
            check("bgo_end", background_rewrite, 1'b0);
            check("stop_free", grant, 1'b1);
        end
        stop_req = 1'b0;
    endtask : cmd_go
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(`DFA_CTRL_ADDR, 1'b0, 8'h00);
        rd(20'hF1005, 1'b1, 8'h00);
        cmd_go(DFA_OP_ERASE, 20'hF1000, 8'h00, 1'b1);
    endtask : t_reset
    task automatic t_ctrl;
        wr(`DFA_CTRL_ADDR, 8'hFF);
        rd(`DFA_CTRL_ADDR, 1'b0, 8'h01);
        cpu(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, `DFA_CTRL_ADDR, 8'h00, 1'b0, 0);
        rd(`DFA_CTRL_ADDR, 1'b0, 8'h00);
        cpu(1'b1, 1'b0, 1'b0, 1'b1, 3'h3, `DFA_CTRL_ADDR, 8'h01, 1'b0, 0);
        rd(`DFA_CTRL_ADDR, 1'b0, 8'h00);
        cpu(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, `DFA_CTRL_ADDR, 8'h01, 1'b0, 0);
        rd(`DFA_CTRL_ADDR, 1'b0, 8'h01);
    endtask : t_ctrl
    task automatic t_read;
        rd(20'hF1005, 1'b0, 8'h5F);
        rd(20'hF17FF, 1'b0, 8'hA5);
        cpu(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 20'hF1005, 0, 1'b1, 0);
        cpu(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 20'hF1005, 0, 1'b1, 0);
        selfprog = 1'b1;
        rd(20'hF1005, 1'b1, 8'h00);
        selfprog = 1'b0;
    endtask : t_read
    task automatic t_rewrite;
        // Fast oscillator kept running, 30 us settle before any rewrite
        repeat (300) @(negedge i_clk);
        @(negedge i_clk);
        cmd = '{op:DFA_OP_ERASE, addr:20'hF17FF, data:8'h00};
        @(negedge i_clk);
        cmd.op = DFA_OP_NONE;
        req = '{valid:1'b1, write:1'b0, fetch:1'b1, word:1'b0, bit_op:1'b0,
            bit_sel:3'h0, addr:20'h00100, wdata:8'h00};
        @(negedge i_clk);
        check("cf_fetch", cf_fetch, 1'b1);
        check("bgo_fetch", background_rewrite, 1'b1);
        req.valid = 1'b0;
        wr(`DFA_CTRL_ADDR, 8'h00);
        rd(20'hF1005, 1'b1, 8'h00);
        repeat (10) @(negedge i_clk);
        rd(`DFA_CTRL_ADDR, 1'b0, 8'h01);
        rd(20'hF1400, 1'b0, 8'hFF);
        rd(20'hF13FF, 1'b0, 8'hA5);
        selfprog = 1'b1;
        cmd_go(DFA_OP_PROG, 20'hF1400, 8'h3C, 1'b1);
        selfprog = 1'b0;
        irq_en = 1'b1;
        cmd_go(DFA_OP_PROG, 20'hF1400, 8'h3C, 1'b1);
        irq_en = 1'b0;
        cmd_go(DFA_OP_PROG, 20'hF1400, 8'h3C, 1'b0);
        rd(20'hF1400, 1'b0, 8'h3C);
    endtask : t_rewrite
    task automatic t_serial;
        wr(`DFA_CTRL_ADDR, 8'h00);
        cmd_go(DFA_OP_PROG, 20'hF1401, 8'h00, 1'b1);
        spin = 1'b1;
        irq_en = 1'b1;
        repeat (3) @(negedge i_clk);
        cmd_go(DFA_OP_ERASE, 20'hF1000, 8'h00, 1'b0);
        spin = 1'b0;
        irq_en = 1'b0;
    endtask : t_serial
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_rstn = 1'b1;
        t_reset();
        t_ctrl();
        t_read();
        t_rewrite();
        t_serial();
        close_out();
    end
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
